// ---- rsi_pkg.sv ----
// Shared constants and types for the clock/SRAM/EEPROM two-wire access block
package rsi_pkg;

    // ------------------------------------------------------------
    // Control bytes (upper seven bits, direction bit stripped)
    // ------------------------------------------------------------
    localparam logic [6:0] CTRL_RTCC = 7'h6F;
    localparam logic [6:0] CTRL_EE = 7'h57;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RTCC_BEG = 8'h00;
    localparam logic [7:0] ADDR_RTCC_END = 8'h1F;
    localparam logic [7:0] ADDR_SRAM_BEG = 8'h20;
    localparam logic [7:0] ADDR_SRAM_END = 8'h5F;
    localparam logic [7:0] ADDR_EE_BEG = 8'hF0;
    localparam logic [7:0] ADDR_EE_END = 8'hF7;
    localparam logic [7:0] ADDR_UNLOCK = 8'h09;
    localparam int MEM_WORDS = 96;
    localparam int EE_WORDS = 8;

    // ------------------------------------------------------------
    // Unlock keys and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [7:0] EE_ERASED = 8'hFF;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Write buffer shape and timing
    // ------------------------------------------------------------
    localparam int FIFO_W = 15;
    localparam int FIFO_D = 4;
    localparam int CLK_NS = 5;
    localparam int EE_WR_NS = 5000000;
    localparam int EE_WR_CYC_DEF = EE_WR_NS / CLK_NS;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} rsi_state_t;
    typedef enum logic [1:0] {K_CTRL, K_ADDR, K_DATA} rsi_kind_t;
    typedef enum logic [1:0] {LK_NONE, LK_HALF, LK_OPEN} rsi_lock_t;

endpackage

// ---- rsi_fifo_if.sv ----
// Valid/ready carrier between the access core and its write buffer
`timescale 1ns/1ps
interface rsi_fifo_if #(parameter int W = 15);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport store (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
    modport user (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready);
endinterface

// ---- rsi_fifo.sv ----
// Small first-in first-out buffer for pending memory writes
`timescale 1ns/1ps
module rsi_fifo import rsi_pkg::*; #(
    parameter int W = 15,
    parameter int D = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    rsi_fifo_if.store f
);
    localparam int AW = $clog2(D);

    logic [W-1:0] buf_r [0:D-1];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic full;
    logic empty;

    // ------------------------------------------------------------
    // Flags: extra pointer bit tells full from empty
    // ------------------------------------------------------------
    assign empty = (wp_r == rp_r);
    assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    assign f.in_ready = ~full;
    assign f.out_valid = ~empty;
    assign f.out_data = buf_r[rp_r[AW-1:0]];

    // Storage, no reset needed on the data itself
    always_ff @(posedge i_clk_sys) begin
        if (f.in_valid && !full) begin
            buf_r[wp_r[AW-1:0]] <= f.in_data;
        end
    end

    // Pointers
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (f.in_valid && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (f.out_ready && !empty) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule

// ---- rsi_core.sv ----
// Two-wire target access to clock registers, SRAM and protected EEPROM
`timescale 1ns/1ps
module rsi_core import rsi_pkg::*; #(
    parameter int EE_WR_CYC = EE_WR_CYC_DEF
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_ee_busy,
    output logic [7:0] o_ptr
);
    localparam int EE_CW = $clog2(EE_WR_CYC + 1);

    // ------------------------------------------------------------
    // Address helpers
    // ------------------------------------------------------------
    function automatic logic in_ee(input logic [7:0] a);
        in_ee = (a >= ADDR_EE_BEG) && (a <= ADDR_EE_END);
    endfunction

    // Each block rolls over onto its own start
    function automatic logic [7:0] next_ptr(input logic [7:0] a);
        if (a == ADDR_RTCC_END) begin
            next_ptr = ADDR_RTCC_BEG;
        end else if (a == ADDR_SRAM_END) begin
            next_ptr = ADDR_SRAM_BEG;
        end else if (a == ADDR_EE_END) begin
            next_ptr = ADDR_EE_BEG;
        end else begin
            next_ptr = 8'(a + 8'h01);
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rsi_state_t st_r;
    rsi_kind_t kind_r;
    rsi_lock_t lock_r;
    logic scl_q_r;
    logic sda_q_r;
    logic [3:0] cnt_r;
    logic [7:0] rx_sh_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic ack_r;
    logic rd_r;
    logic ee_sp_r;
    logic macked_r;
    logic sda_oe_r;
    logic sda_out_r;
    logic ee_wdat_r;
    logic ee_busy_r;
    logic [EE_CW-1:0] ee_cnt_r;
    logic [7:0] mem [0:MEM_WORDS-1];
    logic [7:0] ee_mem_r [0:EE_WORDS-1];
    logic [7:0] page_r [0:EE_WORDS-1];
    logic [EE_WORDS-1:0] mask_r;

    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic cmd_end;
    logic ack_eval;
    logic ack_ok;
    logic wr_take;
    logic addr_take;
    logic tx_load;
    logic key_wr;
    logic [7:0] rd_byte;

    rsi_fifo_if #(.W(FIFO_W)) wq ();

    rsi_fifo #(.W(FIFO_W), .D(FIFO_D)) u_wq (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .f(wq)
    );

    // ------------------------------------------------------------
    // Bus conditions; pins are already in the clock domain
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= i_scl;
            sda_q_r <= i_sda;
        end
    end

    assign scl_rise = i_scl & ~scl_q_r;
    assign scl_fall = ~i_scl & scl_q_r;
    assign start = scl_q_r & i_scl & sda_q_r & ~i_sda;
    assign stop = scl_q_r & i_scl & ~sda_q_r & i_sda;
    assign cmd_end = start | stop;
    assign ack_eval = (st_r == ST_RX) && scl_fall && (cnt_r == 4'h8);
    assign wr_take = ack_eval && (kind_r == K_DATA) && ack_ok;
    assign addr_take = ack_eval && (kind_r == K_ADDR) && ack_ok;
    assign key_wr = wr_take && !ee_sp_r && (ptr_r == ADDR_UNLOCK);
    assign tx_load = scl_fall && (((st_r == ST_ACK) && rd_r && ack_r) || ((st_r == ST_MACK) && macked_r));

    // ------------------------------------------------------------
    // Acknowledge decision for the byte just shifted in
    // ------------------------------------------------------------
    always_comb begin
        ack_ok = 1'b0;
        case (kind_r)
            K_CTRL: begin
                ack_ok = (rx_sh_r[7:1] == CTRL_RTCC) || ((rx_sh_r[7:1] == CTRL_EE) && !ee_busy_r);
            end
            K_ADDR: begin
                ack_ok = ee_sp_r ? in_ee(rx_sh_r) : (rx_sh_r <= ADDR_SRAM_END);
            end
            K_DATA: begin
                // Full write buffer is refused rather than dropped
                ack_ok = ee_sp_r || (ptr_r == ADDR_UNLOCK) || wq.in_ready;
            end
            default: begin
                ack_ok = 1'b0;
            end
        endcase
    end

    // Byte offered to the master at the current pointer
    always_comb begin
        rd_byte = BYTE_ZERO;
        if (ee_sp_r) begin
            if (in_ee(ptr_r)) begin
                rd_byte = ee_mem_r[ptr_r[2:0]];
            end
        end else if ((ptr_r != ADDR_UNLOCK) && (ptr_r <= ADDR_SRAM_END)) begin
            rd_byte = mem[ptr_r[6:0]];
        end
    end

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= ST_IDLE;
            kind_r <= K_CTRL;
            cnt_r <= 4'h0;
            rx_sh_r <= BYTE_ZERO;
            tx_r <= BYTE_ZERO;
            ack_r <= 1'b0;
            rd_r <= 1'b0;
            ee_sp_r <= 1'b0;
            macked_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (stop) begin
            st_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else if (start) begin
            st_r <= ST_RX;
            kind_r <= K_CTRL;
            cnt_r <= 4'h0;
            rd_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            case (st_r)
                ST_RX: begin
                    if (scl_rise) begin
                        rx_sh_r <= {rx_sh_r[6:0], i_sda};
                        cnt_r <= 4'(cnt_r + 4'h1);
                    end else if (ack_eval) begin
                        st_r <= ST_ACK;
                        ack_r <= ack_ok;
                        sda_oe_r <= ack_ok;
                        if (kind_r == K_CTRL) begin
                            rd_r <= rx_sh_r[0];
                            ee_sp_r <= (rx_sh_r[7:1] == CTRL_EE);
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_r <= 4'h0;
                        if (!ack_r) begin
                            st_r <= ST_IDLE;
                            sda_oe_r <= 1'b0;
                        end else if (rd_r) begin
                            st_r <= ST_TX;
                            tx_r <= rd_byte;
                            sda_oe_r <= ~rd_byte[7];
                        end else begin
                            st_r <= ST_RX;
                            sda_oe_r <= 1'b0;
                            kind_r <= (kind_r == K_CTRL) ? K_ADDR : K_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_r == 4'h7) begin
                            st_r <= ST_MACK;
                            sda_oe_r <= 1'b0;
                        end else begin
                            cnt_r <= 4'(cnt_r + 4'h1);
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_oe_r <= ~tx_r[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        macked_r <= ~i_sda;
                    end else if (scl_fall) begin
                        cnt_r <= 4'h0;
                        if (macked_r) begin
                            st_r <= ST_TX;
                            tx_r <= rd_byte;
                            sda_oe_r <= ~rd_byte[7];
                        end else begin
                            st_r <= ST_IDLE;
                            sda_oe_r <= 1'b0;
                        end
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Shared address pointer for every space
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ptr_r <= PTR_RESET;
        end else if (addr_take) begin
            ptr_r <= rx_sh_r;
        end else if (wr_take || tx_load) begin
            ptr_r <= next_ptr(ptr_r);
        end
    end

    // ------------------------------------------------------------
    // Clock/SRAM writes pass through the buffer; reads stall its drain
    // ------------------------------------------------------------
    assign wq.in_valid = wr_take && !ee_sp_r && (ptr_r != ADDR_UNLOCK);
    assign wq.in_data = {ptr_r[6:0], rx_sh_r};
    assign wq.out_ready = ~tx_load;

    // Memory contents are kept across reset on purpose
    always_ff @(posedge i_clk_sys) begin
        if (wq.out_valid && wq.out_ready) begin
            mem[wq.out_data[14:8]] <= wq.out_data[7:0];
        end
    end

    // ------------------------------------------------------------
    // Unlock keys; any other clock/SRAM write breaks the sequence
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lock_r <= LK_NONE;
        end else if (key_wr) begin
            if (rx_sh_r == KEY_FIRST) begin
                lock_r <= LK_HALF;
            end else if ((rx_sh_r == KEY_SECOND) && (lock_r == LK_HALF)) begin
                lock_r <= LK_OPEN;
            end else begin
                lock_r <= LK_NONE;
            end
        end else if (wr_take && !ee_sp_r) begin
            lock_r <= LK_NONE;
        end else if (cmd_end && ee_wdat_r) begin
            lock_r <= LK_NONE;
        end
    end

    // Marks a command that carried EEPROM data, locked or not
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ee_wdat_r <= 1'b0;
        end else if (cmd_end) begin
            ee_wdat_r <= 1'b0;
        end else if (wr_take && ee_sp_r) begin
            ee_wdat_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // EEPROM page buffer and timed write cycle
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ee_busy_r <= 1'b0;
            ee_cnt_r <= '0;
            mask_r <= '0;
            for (int i = 0; i < EE_WORDS; i++) begin
                page_r[i] <= EE_ERASED;
                ee_mem_r[i] <= EE_ERASED;
            end
        end else if (ee_busy_r) begin
            if (ee_cnt_r == '0) begin
                ee_busy_r <= 1'b0;
                mask_r <= '0;
                for (int i = 0; i < EE_WORDS; i++) begin
                    if (mask_r[i]) begin
                        ee_mem_r[i] <= page_r[i];
                    end
                end
            end else begin
                ee_cnt_r <= EE_CW'(ee_cnt_r - 1'b1);
            end
        end else if (cmd_end && (mask_r != '0)) begin
            ee_busy_r <= 1'b1;
            ee_cnt_r <= EE_CW'(EE_WR_CYC - 1);
        end else if (wr_take && ee_sp_r && (lock_r == LK_OPEN)) begin
            page_r[ptr_r[2:0]] <= rx_sh_r;
            mask_r[ptr_r[2:0]] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sda_out_r <= 1'b0;
        end else begin
            sda_out_r <= 1'b0;
        end
    end

    assign o_sda_out = sda_out_r;
    assign o_sda_oe = sda_oe_r;
    assign o_ee_busy = ee_busy_r;
    assign o_ptr = ptr_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_high_addr_nack;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (ack_eval && kind_r == K_ADDR && !ee_sp_r && rx_sh_r > ADDR_SRAM_END) |=> !sda_oe_r[*2];
    endproperty
    a_high_addr_nack: assert property (p_high_addr_nack)
        else $error("clock/SRAM address above range was acknowledged");

    property p_ee_range_nack;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (ack_eval && kind_r == K_ADDR && ee_sp_r && !in_ee(rx_sh_r)) |=> (!sda_oe_r && st_r == ST_ACK);
    endproperty
    a_ee_range_nack: assert property (p_ee_range_nack)
        else $error("EEPROM address outside range was acknowledged");

    property p_busy_nack;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (ack_eval && kind_r == K_CTRL && rx_sh_r[7:1] == CTRL_EE && ee_busy_r) |=> !sda_oe_r;
    endproperty
    a_busy_nack: assert property (p_busy_nack)
        else $error("EEPROM control acknowledged during write cycle");

    property p_data_ack;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_take |=> (sda_oe_r && ptr_r == next_ptr($past(ptr_r)));
    endproperty
    a_data_ack: assert property (p_data_ack)
        else $error("accepted data byte not acknowledged or pointer not advanced");

    property p_wrap_rtcc;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (wr_take && ptr_r == ADDR_RTCC_END) |=> ptr_r == ADDR_RTCC_BEG;
    endproperty
    a_wrap_rtcc: assert property (p_wrap_rtcc)
        else $error("write pointer did not wrap inside clock block");

    property p_wrap_sram_rd;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (tx_load && ptr_r == ADDR_SRAM_END) |=> ptr_r == ADDR_SRAM_BEG;
    endproperty
    a_wrap_sram_rd: assert property (p_wrap_sram_rd)
        else $error("read pointer did not wrap inside SRAM block");

    property p_key_reads_zero;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (tx_load && !ee_sp_r && ptr_r == ADDR_UNLOCK) |=> tx_r == BYTE_ZERO;
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero)
        else $error("unlock port read was not zero");

    property p_relock;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (cmd_end && ee_wdat_r) |=> (lock_r == LK_NONE);
    endproperty
    a_relock: assert property (p_relock)
        else $error("EEPROM not relocked after write command");

    property p_busy_holds;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(ee_busy_r) |-> ee_busy_r[*8];
    endproperty
    a_busy_holds: assert property (p_busy_holds)
        else $error("EEPROM write cycle ended too early");
endmodule

// ---- rsi_master.sv ----
// Behavioural two-wire bus master that drives the access block
`timescale 1ns/1ps
module rsi_master (
    input wire logic i_clk_sys,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // Third of a bit in clocks; the bench raises it for a slow bus
    int hp_cyc = 4;
    // Set both lines, hold a third of a bit; moves land 1 ns after an edge
    task automatic ph(input logic c, input logic d);
        o_scl = c;
        o_sda = d;
        repeat (hp_cyc) @(posedge i_clk_sys);
        #1;
    endtask
    // Start or repeated start: data falls while the clock is high
    task automatic start();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b0, 1'b0);
    endtask
    // Stop: data rises while the clock is high
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    // Nine bits MSB first, sampled late in the high phase; bit 0 is the ack
    task automatic xbyte(input logic [8:0] o, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, o[i]);
            ph(1'b1, o[i]);
            r[i] = i_sda;
            ph(1'b0, o[i]);
        end
    endtask
endmodule

// ---- tb_rsi_core.sv ----
// Self-checking bench for the two-wire memory access block
`timescale 1ns/1ps
module tb_rsi_core import rsi_pkg::*;;
    localparam int EEC = 1200;
    localparam logic [7:0] CW = {CTRL_RTCC, 1'b0};
    localparam logic [7:0] EW = {CTRL_EE, 1'b0};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda_m, sda_out, sda_oe, ee_busy;
    logic [7:0] ptr;
    logic [8:0] r;
    int errors = 0;
    int cmp_count = 0;
    int bcnt = 0;
    // Pulled-up data line: low while either side pulls
    wire sda = sda_m & (sda_oe ? sda_out : 1'b1);
    // 200 MHz clock
    initial forever #2.5 clk = ~clk;
    // Clocks spent in the internal write cycle
    always @(posedge clk) bcnt <= bcnt + int'(ee_busy === 1'b1);
    rsi_core #(.EE_WR_CYC(EEC)) i_rsi_core (.i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_ee_busy(ee_busy), .o_ptr(ptr));
    rsi_master i_rsi_master (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
    // Compare and count; a mismatch is reported at once
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic conclude();
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One byte out; nk is the expected ack bit, 1 when refused
    task automatic wb(input logic [7:0] b, input logic nk);
        i_rsi_master.xbyte({b, 1'b1}, r);
        check({7'h00, r[0]}, {7'h00, nk});
    endtask
    // Write command; a refused address also refuses the data
    task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] q[$], input logic na);
        i_rsi_master.start();
        wb(c, 1'b0);
        wb(a, na);
        foreach (q[i]) begin
            wb(q[i], na);
        end
        i_rsi_master.stop();
    endtask
    // Read, after an address phase and repeated start when ra is set
    task automatic rd(input logic [7:0] c, input logic ra, input logic [7:0] a, input logic [7:0] e[$]);
        if (ra) begin
            i_rsi_master.start();
            wb(c, 1'b0);
            wb(a, 1'b0);
        end
        i_rsi_master.start();
        wb(c | 8'h01, 1'b0);
        foreach (e[i]) begin
            i_rsi_master.xbyte({8'hFF, (i == e.size() - 1)}, r);
            check(r[8:1], e[i]);
        end
        i_rsi_master.stop();
    endtask
    // Writes and reads, with roll-over at both block ends
    task automatic s_rw();
        wr(CW, 8'h20, '{8'h5A}, 1'b0);
        check(ptr, 8'h21);
        wr(CW, 8'h21, '{8'hA5, 8'h3C}, 1'b0);
        rd(CW, 1'b1, 8'h20, '{8'h5A});
        rd(CW, 1'b0, 8'h00, '{8'hA5, 8'h3C});
        check(ptr, 8'h23);
        i_rsi_master.hp_cyc = 8;
        wr(CW, 8'h1E, '{8'h11, 8'h22, 8'h33}, 1'b0);
        check(ptr, 8'h01);
        wr(CW, 8'h5E, '{8'h44, 8'h55, 8'h66}, 1'b0);
        check(ptr, 8'h21);
        i_rsi_master.hp_cyc = 4;
        rd(CW, 1'b1, 8'h1F, '{8'h22, 8'h33});
        rd(CW, 1'b1, 8'h5F, '{8'h55, 8'h66, 8'hA5});
    endtask
    // Refused addresses and control byte; the next command still goes
    task automatic s_refuse();
        wr(CW, 8'h60, '{8'h99}, 1'b1);
        wr(EW, 8'hF8, '{8'h99}, 1'b1);
        i_rsi_master.start();
        wb(8'hD0, 1'b1);
        wr(CW, 8'h5F, '{8'h7E}, 1'b0);
        rd(CW, 1'b1, 8'h5F, '{8'h7E, 8'h66});
    endtask
    // Locked, unlocked and relocked EEPROM writes around one write cycle
    task automatic s_eeprom();
        rd(EW, 1'b1, 8'hF0, '{EE_ERASED, EE_ERASED});
        wr(EW, 8'hF0, '{8'hC3}, 1'b0);
        check({7'h00, ee_busy}, 8'h00);
        wr(CW, ADDR_UNLOCK, '{KEY_FIRST}, 1'b0);
        wr(CW, ADDR_UNLOCK, '{KEY_SECOND}, 1'b0);
        wr(EW, 8'hF6, '{8'hC3, 8'h3C, 8'h5A}, 1'b0);
        check(ptr, 8'hF1);
        i_rsi_master.start();
        wb(EW, 1'b1);
        wr(CW, 8'h40, '{8'h81}, 1'b0);
        rd(CW, 1'b1, 8'h40, '{8'h81});
        check({7'h00, ee_busy}, 8'h01);
        // Bounded wait; a cycle that never ends is counted as a mismatch
        for (int n = 0; n < 1000 && ee_busy === 1'b1; n++) begin
            @(posedge clk);
        end
        #1;
        check({7'h00, ee_busy}, 8'h00);
        check(8'(bcnt >= EEC && bcnt <= EEC + 1), 8'h01);
        rd(EW, 1'b1, 8'hF6, '{8'hC3, 8'h3C, 8'h5A, EE_ERASED});
        rd(CW, 1'b1, ADDR_UNLOCK, '{BYTE_ZERO});
        wr(EW, 8'hF1, '{8'h77}, 1'b0);
        check({7'h00, ee_busy}, 8'h00);
    endtask
    // Idle bus through a 12-clock reset, then the scenarios
    initial begin
        i_rsi_master.ph(1'b1, 1'b1);
        repeat (8) @(posedge clk);
        #1;
        check(ptr, PTR_RESET);
        check({6'h00, sda_oe, ee_busy}, 8'h00);
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        s_rw();
        s_refuse();
        s_eeprom();
        conclude();
    end
endmodule
